// File: hw/dvm_defines.vh
`ifndef DVM_DEFINES_VH
`define DVM_DEFINES_VH

// Register byte addresses
`define DVM_A_CTRL        8'h00
`define DVM_A_STATUS      8'h04
`define DVM_A_MODE        8'h08
`define DVM_A_MODE_DISP   8'h0C
`define DVM_A_TARGET      8'h10
`define DVM_A_DEMAND      8'h14
`define DVM_A_EFFORT      8'h18
`define DVM_A_CTRL_SRC    8'h1C
`define DVM_A_CONFIG      8'h20
`define DVM_A_AUX_SEL     8'h24
`define DVM_A_RISE_POS    8'h28
`define DVM_A_FALL_POS    8'h2C
`define DVM_A_RISE_NEG    8'h30
`define DVM_A_FALL_NEG    8'h34
`define DVM_A_DECEL       8'h38
`define DVM_A_POLES       8'h3C
`define DVM_A_FREQ        8'h40

// Control word bit positions
`define DVM_CW_ON         0
`define DVM_CW_VOLT       1
`define DVM_CW_QSTOP      2
`define DVM_CW_ENOP       3
`define DVM_CW_RFG_EN     4
`define DVM_CW_RFG_UNLOCK 5
`define DVM_CW_RFG_REF    6
`define DVM_CW_HALT       8

// Status word bit positions and patterns
`define DVM_SW_REMOTE     9
`define DVM_SW_TARGET     10
`define DVM_SW_DISABLED   8'h50
`define DVM_SW_READY      8'h31
`define DVM_SW_SWON       8'h33
`define DVM_SW_OPEN       8'h37

// Mode and configuration codes
`define DVM_MODE_VELOCITY 16'h0002
`define DVM_SRC_STATEMACH 16'h0001
`define DVM_CFG_POSCTL    16'h0040
`define DVM_AUX_ZERO      16'h0009

// Reset values
`define DVM_RST_MODE      16'h0002
`define DVM_RST_CTRL_SRC  16'h0001
`define DVM_RST_CONFIG    16'h0040
`define DVM_RST_AUX_SEL   16'h0009
`define DVM_RST_RAMP      16'h0001
`define DVM_RST_POLES     16'h0002

// Ramp tick: time in us, clock in MHz, cycles derived
`define DVM_TICK_US       1000
`define DVM_CLK_MHZ       25
`define DVM_TICK_CYC      (`DVM_TICK_US * `DVM_CLK_MHZ)

// Frequency conversion: 0.01 Hz = rpm * poles * 5 / 3
`define DVM_FREQ_MUL      5
`define DVM_DIV3_MUL      21846
`define DVM_DIV3_SHIFT    16

`endif

// File: hw/dvm_ramp.v
`timescale 1ns/1ps
`include "dvm_defines.vh"

module dvm_ramp (
    sys_clk,
    reset,
    clear,
    tick,
    hold,
    setpoint,
    interval,
    value
);
    input                    sys_clk;
    input                    reset;
    input                    clear;
    input                    tick;
    input                    hold;
    input  wire signed [15:0] setpoint;
    input  wire [15:0]       interval;
    output reg signed [15:0] value;

    reg  [15:0] cnt_q;
    wire        step;

    assign step = tick && !hold && (value != setpoint) &&
                  (cnt_q + 16'h0001 >= interval);

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt_q <= 16'h0000;
            value <= 16'sh0000;
        end else if (clear) begin
            cnt_q <= 16'h0000;
            value <= 16'sh0000;
        end else if (tick && !hold) begin
            if (step) begin
                cnt_q <= 16'h0000;
                if (setpoint > value) begin
                    value <= value + 16'sh0001;
                end else begin
                    value <= value - 16'sh0001;
                end
            end else if (value != setpoint) begin
                cnt_q <= cnt_q + 16'h0001;
            end else begin
                cnt_q <= 16'h0000;
            end
        end
    end
endmodule

// File: hw/dvm_top.v
`timescale 1ns/1ps
`include "dvm_defines.vh"

module dvm_top #(
    parameter TICK_CYCLES = `DVM_TICK_CYC
) (
    sys_clk,
    reset,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    aux_ref,
    speed_ref,
    freq_ref,
    op_enabled
);
    input                    sys_clk;
    input                    reset;
    input  wire [7:0]        reg_addr;
    input  wire [15:0]       reg_wdata;
    input                    reg_wr;
    input                    reg_rd;
    output reg  [15:0]       reg_rdata;
    input  wire signed [15:0] aux_ref;
    output reg  signed [15:0] speed_ref;
    output reg  [31:0]       freq_ref;
    output wire              op_enabled;

    localparam [3:0] ST_DISABLED = 4'b0001;
    localparam [3:0] ST_READY    = 4'b0010;
    localparam [3:0] ST_SWON     = 4'b0100;
    localparam [3:0] ST_OPEN     = 4'b1000;

    reg  [15:0]        ctrl_q;
    reg  [15:0]        mode_q;
    reg  [15:0]        disp_q;
    reg  signed [15:0] target_q;
    reg  [15:0]        src_q;
    reg  [15:0]        cfg_q;
    reg  [15:0]        aux_sel_q;
    reg  [15:0]        rise_pos_q;
    reg  [15:0]        fall_pos_q;
    reg  [15:0]        rise_neg_q;
    reg  [15:0]        fall_neg_q;
    reg  [15:0]        decel_q;
    reg  [15:0]        poles_q;
    reg  [3:0]         state_q;
    reg  [3:0]         state_d;
    reg  [15:0]        rdata_d;
    reg  [15:0]        interval_d;
    reg  [31:0]        tick_cnt_q;
    reg                tick_q;

    wire               wr_ctrl;
    wire               mode_settled;
    wire               vel_active;
    wire               halt;
    wire               hold;
    wire               use_ramp;
    wire signed [15:0] setpoint;
    wire signed [15:0] ramp_val;
    wire signed [15:0] effort_d;
    wire [15:0]        status_w;
    wire [7:0]         status_lo;
    wire               target_hit;
    wire [15:0]        abs_effort;
    wire [63:0]        freq_prod;

    assign wr_ctrl = reg_wr && (reg_addr == `DVM_A_CTRL);

    // Power state machine driven by control-word writes
    always @* begin
        state_d = state_q;
        if (wr_ctrl) begin
            if (!reg_wdata[`DVM_CW_VOLT] || !reg_wdata[`DVM_CW_QSTOP]) begin
                state_d = ST_DISABLED;
            end else if (!reg_wdata[`DVM_CW_ON]) begin
                state_d = ST_READY;
            end else if (!reg_wdata[`DVM_CW_ENOP]) begin
                case (state_q)
                    ST_READY: begin
                        state_d = ST_SWON;
                    end
                    ST_OPEN: begin
                        state_d = ST_SWON;
                    end
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end else begin
                case (state_q)
                    ST_SWON: begin
                        state_d = ST_OPEN;
                    end
                    ST_OPEN: begin
                        state_d = ST_OPEN;
                    end
                    default: begin
                        state_d = state_q;
                    end
                endcase
            end
        end
    end

    // Word registers, sampled once per clock
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_q     <= 16'h0000;
            mode_q     <= `DVM_RST_MODE;
            disp_q     <= `DVM_RST_MODE;
            target_q   <= 16'sh0000;
            src_q      <= `DVM_RST_CTRL_SRC;
            cfg_q      <= `DVM_RST_CONFIG;
            aux_sel_q  <= `DVM_RST_AUX_SEL;
            rise_pos_q <= `DVM_RST_RAMP;
            fall_pos_q <= `DVM_RST_RAMP;
            rise_neg_q <= `DVM_RST_RAMP;
            fall_neg_q <= `DVM_RST_RAMP;
            decel_q    <= `DVM_RST_RAMP;
            poles_q    <= `DVM_RST_POLES;
            state_q    <= ST_DISABLED;
        end else begin
            state_q <= state_d;
            disp_q  <= mode_q;
            if (reg_wr) begin
                if (reg_addr == `DVM_A_CTRL) begin
                    ctrl_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_MODE) begin
                    mode_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_TARGET) begin
                    target_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_CTRL_SRC) begin
                    src_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_CONFIG) begin
                    cfg_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_AUX_SEL) begin
                    aux_sel_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_RISE_POS) begin
                    rise_pos_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_FALL_POS) begin
                    fall_pos_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_RISE_NEG) begin
                    rise_neg_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_FALL_NEG) begin
                    fall_neg_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_DECEL) begin
                    decel_q <= reg_wdata;
                end else if (reg_addr == `DVM_A_POLES) begin
                    poles_q <= reg_wdata;
                end
            end
        end
    end

    assign op_enabled   = state_q[3];
    assign mode_settled = (mode_q == disp_q);
    // Mode bits act only in full motion-control setup
    assign vel_active = op_enabled && mode_settled &&
                        (src_q == `DVM_SRC_STATEMACH) &&
                        (cfg_q == `DVM_CFG_POSCTL) &&
                        (mode_q == `DVM_MODE_VELOCITY);

    assign halt     = ctrl_q[`DVM_CW_HALT];
    assign hold     = !ctrl_q[`DVM_CW_RFG_UNLOCK] && !halt;
    assign setpoint = (halt || !ctrl_q[`DVM_CW_RFG_REF]) ?
                      16'sh0000 : target_q;
    assign use_ramp = ctrl_q[`DVM_CW_RFG_EN] ||
                      (aux_sel_q == `DVM_AUX_ZERO);
    assign effort_d = use_ramp ? ramp_val : aux_ref;

    // Rate pick: halt uses deceleration, else rise or fall by sign
    always @* begin
        if (halt) begin
            interval_d = decel_q;
        end else if (ramp_val >= 16'sh0000 && setpoint > ramp_val) begin
            interval_d = rise_pos_q;
        end else if (ramp_val > 16'sh0000) begin
            interval_d = fall_pos_q;
        end else if (setpoint < ramp_val) begin
            interval_d = rise_neg_q;
        end else begin
            interval_d = fall_neg_q;
        end
    end

    // Ramp time base
    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= TICK_CYCLES - 1) begin
            tick_cnt_q <= 32'h00000000;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h00000001;
            tick_q     <= 1'b0;
        end
    end

    dvm_ramp u_ramp (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .clear    (!vel_active),
        .tick     (tick_q),
        .hold     (hold),
        .setpoint (setpoint),
        .interval (interval_d),
        .value    (ramp_val)
    );

    // rpm to 0.01 Hz
    assign abs_effort = effort_d[15] ? (16'h0000 - effort_d) : effort_d;
    assign freq_prod  = abs_effort * poles_q * `DVM_FREQ_MUL *
                        `DVM_DIV3_MUL;

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            speed_ref <= 16'sh0000;
            freq_ref  <= 32'h00000000;
        end else if (vel_active) begin
            speed_ref <= effort_d;
            freq_ref  <= freq_prod[`DVM_DIV3_SHIFT +: 32];
        end else begin
            speed_ref <= 16'sh0000;
            freq_ref  <= 32'h00000000;
        end
    end

    assign target_hit = vel_active && (ramp_val == setpoint);
    assign status_lo  = state_q[3] ? `DVM_SW_OPEN :
                        state_q[2] ? `DVM_SW_SWON :
                        state_q[1] ? `DVM_SW_READY : `DVM_SW_DISABLED;
    assign status_w   = {5'b00000, target_hit,
                         (src_q == `DVM_SRC_STATEMACH), 1'b0, status_lo};

    // Register read, data one cycle after strobe
    always @* begin
        rdata_d = 16'h0000;
        if (reg_addr == `DVM_A_CTRL) begin
            rdata_d = ctrl_q;
        end else if (reg_addr == `DVM_A_STATUS) begin
            rdata_d = status_w;
        end else if (reg_addr == `DVM_A_MODE) begin
            rdata_d = mode_q;
        end else if (reg_addr == `DVM_A_MODE_DISP) begin
            rdata_d = disp_q;
        end else if (reg_addr == `DVM_A_TARGET) begin
            rdata_d = target_q;
        end else if (reg_addr == `DVM_A_DEMAND) begin
            rdata_d = ramp_val;
        end else if (reg_addr == `DVM_A_EFFORT) begin
            rdata_d = speed_ref;
        end else if (reg_addr == `DVM_A_CTRL_SRC) begin
            rdata_d = src_q;
        end else if (reg_addr == `DVM_A_CONFIG) begin
            rdata_d = cfg_q;
        end else if (reg_addr == `DVM_A_AUX_SEL) begin
            rdata_d = aux_sel_q;
        end else if (reg_addr == `DVM_A_RISE_POS) begin
            rdata_d = rise_pos_q;
        end else if (reg_addr == `DVM_A_FALL_POS) begin
            rdata_d = fall_pos_q;
        end else if (reg_addr == `DVM_A_RISE_NEG) begin
            rdata_d = rise_neg_q;
        end else if (reg_addr == `DVM_A_FALL_NEG) begin
            rdata_d = fall_neg_q;
        end else if (reg_addr == `DVM_A_DECEL) begin
            rdata_d = decel_q;
        end else if (reg_addr == `DVM_A_POLES) begin
            rdata_d = poles_q;
        end else if (reg_addr == `DVM_A_FREQ) begin
            rdata_d = freq_ref[15:0];
        end
    end

    always @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// File: testbench/dvm_monitor.sv
`timescale 1ns/1ps
module dvm_monitor (
    input wire logic               sys_clk,
    input wire logic               reset,
    input wire logic [7:0]         reg_addr,
    input wire logic [15:0]        reg_wdata,
    input wire logic               reg_wr,
    input wire logic               reg_rd,
    input wire logic [15:0]        reg_rdata,
    input wire logic signed [15:0] speed_ref,
    input wire logic [31:0]        freq_ref,
    input wire logic               op_enabled
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_unmap;
        reg_rd && reg_addr == 8'hFC |=> reg_rdata == 16'h0000;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_ctrl_rb;
        reg_wr && reg_addr == 8'h00 ##2 reg_rd && reg_addr == 8'h00
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_ctrl_rb: assert property (p_ctrl_rb)
        else $error("control word readback wrong");
    property p_disp;
        reg_wr && reg_addr == 8'h08 ##2 reg_rd && reg_addr == 8'h0C
            |=> reg_rdata == $past(reg_wdata, 3);
    endproperty
    a_disp: assert property (p_disp)
        else $error("mode display not following mode");
    property p_enop;
        reg_wr && reg_addr == 8'h00 && reg_wdata == 16'h000F && op_enabled
            |=> op_enabled;
    endproperty
    a_enop: assert property (p_enop)
        else $error("enable code left operation");
    property p_stop;
        reg_wr && reg_addr == 8'h00 && !reg_wdata[3] |=> !op_enabled;
    endproperty
    a_stop: assert property (p_stop)
        else $error("operation kept without enable bit");
    property p_status;
        reg_rd && reg_addr == 8'h04 && op_enabled
            |=> reg_rdata[7:0] == 8'h37;
    endproperty
    a_status: assert property (p_status)
        else $error("status pattern wrong while enabled");
    property p_off;
        !op_enabled [*3] |-> speed_ref == 16'sh0000;
    endproperty
    a_off: assert property (p_off)
        else $error("speed output while not enabled");
    property p_freq;
        speed_ref == 16'sh0000 |-> freq_ref == 32'h00000000;
    endproperty
    a_freq: assert property (p_freq)
        else $error("frequency without speed");
    c_enabled: cover property ($rose(op_enabled));
    c_halt: cover property (reg_wr && reg_addr == 8'h00 && reg_wdata[8]);
    c_moving: cover property (speed_ref == 16'sh0014);
endmodule

bind dvm_top dvm_monitor mon_inst (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .speed_ref(speed_ref),
    .freq_ref(freq_ref), .op_enabled(op_enabled));

// File: testbench/dvm_plc.sv
`timescale 1ns/1ps
module dvm_plc (
    input  wire logic        sys_clk,
    input  wire logic [15:0] reg_rdata,
    output logic [7:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd
);
    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 16'hFFFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // One word per strobe; idle bus shows the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin \
    cmp_count++; \
    if ((g) !== (e)) begin \
        mismatches++; \
        $display("FAIL %0t got %h exp %h", $time, (g), (e)); \
    end \
end
module testbench;
    logic               sys_clk = 1'b0;
    logic               reset = 1'b1;
    logic signed [15:0] aux_ref = 16'h004D;
    wire [7:0]          reg_addr;
    wire [15:0]         reg_wdata;
    wire [15:0]         reg_rdata;
    wire                reg_wr;
    wire                reg_rd;
    wire signed [15:0]  speed_ref;
    wire [31:0]         freq_ref;
    wire                op_enabled;
    int                 mismatches = 0;
    int                 cmp_count = 0;
    int                 cyc = 0;
    logic [15:0]        rdv;
    logic [7:0] ra [14] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h1C, 8'h20,
        8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'hFC};
    logic [15:0] rv [14] = '{16'h0000, 16'h0250, 16'h0002, 16'h0002,
        16'h0001, 16'h0040, 16'h0009, 16'h0001, 16'h0001, 16'h0001,
        16'h0001, 16'h0001, 16'h0002, 16'h0000};

    always #20 sys_clk = ~sys_clk;

    dvm_top #(.TICK_CYCLES(4)) dvm_top_inst (.sys_clk(sys_clk),
        .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .aux_ref(aux_ref), .speed_ref(speed_ref), .freq_ref(freq_ref),
        .op_enabled(op_enabled));
    dvm_plc plc_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd));

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        plc_inst.wr(a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        plc_inst.rd(a, rdv);
        `CHK(rdv, e)
    endtask
    // Bounded wait for the speed output to settle
    task automatic spd(input logic signed [15:0] e);
        int i;
        #1;
        for (i = 0; i < 400 && speed_ref !== e; i++)
            #40;
        `CHK(speed_ref, e)
    endtask
    task summarize;
        $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            mismatches++;
            summarize;
        end
    end

    initial begin
        int i;
        repeat (12) @(posedge sys_clk);
        reset <= 1'b0;
        for (i = 0; i < 14; i++)
            rchk(ra[i], rv[i]);
        wr(8'h00, 16'h0000);
        wr(8'h08, 16'h0002);
        wr(8'h00, 16'h0006);
        rchk(8'h04, 16'h0231);
        wr(8'h00, 16'h0007);
        rchk(8'h04, 16'h0233);
        wr(8'h00, 16'h000F);
        rchk(8'h04, 16'h0637);
        wr(8'h00, 16'h000F);
        rchk(8'h04, 16'h0637);
        wr(8'h10, 16'h0014);
        wr(8'h00, 16'h007F);
        rchk(8'h00, 16'h007F);
        spd(16'h0014);
        rchk(8'h04, 16'h0637);
        rchk(8'h18, 16'h0014);
        rchk(8'h40, 16'h0042);
        wr(8'h00, 16'h005F);
        wr(8'h10, 16'h0005);
        repeat (60) @(posedge sys_clk);
        spd(16'h0014);
        wr(8'h00, 16'h003F);
        spd(16'h0000);
        wr(8'h24, 16'h0000);
        wr(8'h00, 16'h006F);
        spd(16'h004D);
        wr(8'h24, 16'h0009);
        spd(16'h0005);
        wr(8'h00, 16'h017F);
        spd(16'h0000);
        `CHK(op_enabled, 1'b1)
        wr(8'h00, 16'h007F);
        spd(16'h0005);
        wr(8'h28, 16'h0020);
        wr(8'h10, 16'h0008);
        repeat (200) @(posedge sys_clk);
        #1 `CHK(speed_ref < 16'sh0008, 1'b1)
        spd(16'h0008);
        wr(8'h28, 16'h0001);
        wr(8'h00, 16'h0007);
        rchk(8'h04, 16'h0233);
        spd(16'h0000);
        wr(8'h08, 16'h0003);
        rchk(8'h0C, 16'h0003);
        wr(8'h00, 16'h007F);
        repeat (40) @(posedge sys_clk);
        spd(16'h0000);
        wr(8'h00, 16'h0007);
        wr(8'h08, 16'h0002);
        wr(8'h00, 16'h007F);
        spd(16'h0008);
        wr(8'h20, 16'h0000);
        spd(16'h0000);
        wr(8'h20, 16'h0040);
        wr(8'h1C, 16'h0000);
        spd(16'h0000);
        rchk(8'h04, 16'h0037);
        wr(8'h1C, 16'h0001);
        spd(16'h0008);
        wr(8'h04, 16'hFFFF);
        rchk(8'h04, 16'h0637);
        wr(8'h00, 16'h0006);
        rchk(8'h04, 16'h0231);
        spd(16'h0000);
        summarize;
    end
endmodule
